// ===== rtl/scd_param_mem.sv
`timescale 1ns/1ps
`default_nettype none
module scd_param_mem #(
	parameter int DEPTH = 35,
	parameter int AW    = 6,
	parameter int DW    = 8
) (
	// clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	// read port, data one cycle later
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge hclk) begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata <= '0;
		else
			rdata <= mem[raddr];
	end

endmodule
`default_nettype wire

// ===== rtl/scd_pkg.sv
package scd_pkg;

	// command identity
	localparam logic [7:0] SCD_OPCODE     = 8'h22;
	localparam logic [3:0] SCD_DEST       = 4'h4;

	// parameter block: bytes 0 to 34 are kept
	localparam int         SCD_PARAM_LEN  = 35;
	localparam int         SCD_STAGE_W    = SCD_PARAM_LEN * 8;
	localparam int         SCD_IDX_W      = 6;
	localparam logic [5:0] SCD_LAST_IDX   = 6'h22;

	// byte positions inside the parameter block
	localparam int         SCD_B_DSAMPLE  = 3;
	localparam int         SCD_B_STEREO   = 4;
	localparam int         SCD_B_CLKPOL   = 5;
	localparam int         SCD_B_PIXFMT   = 6;
	localparam int         SCD_B_EXTDE    = 7;
	localparam int         SCD_B_ILACE    = 8;
	localparam int         SCD_B_OFFBIN   = 9;
	localparam int         SCD_B_FINV     = 10;
	localparam int         SCD_B_TOT_PPL  = 11;
	localparam int         SCD_B_TOT_LPF  = 13;
	localparam int         SCD_B_ACT_FP   = 15;
	localparam int         SCD_B_ACT_FL   = 17;
	localparam int         SCD_B_ACT_PPL  = 19;
	localparam int         SCD_B_ACT_LPF  = 21;
	localparam int         SCD_B_BOT_FL   = 23;
	localparam int         SCD_B_PCLK     = 25;
	localparam int         SCD_B_COEF0    = 29;
	localparam int         SCD_B_COEF1    = 31;
	localparam int         SCD_B_COEF2    = 33;

	// register byte offsets
	localparam logic [7:0] SCD_OFF_CMD    = 8'h00;
	localparam logic [7:0] SCD_OFF_PARAM  = 8'h04;
	localparam logic [7:0] SCD_OFF_APPLY  = 8'h08;
	localparam logic [7:0] SCD_OFF_STATUS = 8'h0c;
	localparam logic [7:0] SCD_OFF_FLAGS  = 8'h10;
	localparam logic [7:0] SCD_OFF_PCLK   = 8'h14;

	// status field positions
	localparam int         SCD_ST_STAGED  = 2;
	localparam int         SCD_ST_ERR     = 3;
	localparam int         SCD_ST_CNT_LO  = 4;

	// reset values
	localparam logic [15:0] SCD_RST_HALF  = 16'h0000;
	localparam logic [31:0] SCD_RST_WORD  = 32'h0000_0000;

	typedef enum logic [1:0] {
		SCD_IDLE    = 2'b00,
		SCD_COLLECT = 2'b01,
		SCD_UNPACK  = 2'b11,
		SCD_STAGED  = 2'b10
	} scd_state_t;

	function automatic logic [7:0] scd_byte(input logic [SCD_STAGE_W-1:0] s, input int idx);
		scd_byte = s[idx*8 +: 8];
	endfunction

	// multi-byte fields arrive least significant byte first
	function automatic logic [15:0] scd_half(input logic [SCD_STAGE_W-1:0] s, input int idx);
		scd_half = {s[(idx+1)*8 +: 8], s[idx*8 +: 8]};
	endfunction

	function automatic logic [31:0] scd_word(input logic [SCD_STAGE_W-1:0] s, input int idx);
		scd_word = {scd_half(s, idx + 2), scd_half(s, idx)};
	endfunction

endpackage

// ===== rtl/scd_source_config.sv
// Behaviour
// - accept only opcode 22h sent to destination 4 as source configuration
// - byte 4 bit 0 enables stereo operation
// - byte 5 bit 0: one samples on rising edge, zero on falling
// - byte 6 gives pixel format: RGB, YUV444, YUV422, YUV420
// - external data enable honoured only when byte 7 bit 0 is one
// - byte 8 bit 0 selects interlaced, otherwise progressive
// - byte 9 bit 0: zero two's complement, one offset binary
// - byte 10 bit 0 inverts top field at scaler, interlaced only
// - total pixels per line bytes 11-12, total lines bytes 13-14
// - active first pixel, first line, pixels, lines from bytes 15 to 22
// - pixel clock in kilohertz from 32-bit field bytes 25-28
// - conversion coefficients from byte 29 on are signed s2.10
// - down-sampling halves the supplied pixel clock frequency
// - new settings apply only after the display image size command
`timescale 1ns/1ps
`default_nettype none
module scd_source_config
	import scd_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// active port configuration
	output logic             stereo_en,
	output logic             clk_rising,
	output logic      [1:0]  pixel_format,
	output logic             ext_de_en,
	output logic             interlaced,
	output logic             offset_binary,
	output logic             field_invert,
	output logic      [15:0] total_ppl,
	output logic      [15:0] total_lpf,
	output logic      [15:0] act_first_pixel,
	output logic      [15:0] act_first_line,
	output logic      [15:0] act_ppl,
	output logic      [15:0] act_lpf,
	output logic      [15:0] bottom_first_line,
	output logic      [31:0] pixclk_khz,
	output logic      [15:0] color_matrix_conversion_coef0,
	output logic      [15:0] color_matrix_conversion_coef1,
	output logic      [15:0] color_matrix_conversion_coef2
);

	import scd_pkg::*;

	scd_state_t                 state;
	scd_state_t                 next_state;
	logic                       dp_wr;
	logic [7:0]                 dp_addr;
	logic [11:0]                last_hdr;
	logic [SCD_IDX_W-1:0]       param_cnt;
	logic [SCD_IDX_W-1:0]       rd_idx;
	logic                       issued_all;
	logic                       cap_vld;
	logic [SCD_IDX_W-1:0]       cap_idx;
	logic [SCD_STAGE_W-1:0]     stage;
	logic                       hdr_err;
	logic [7:0]                 mem_rdata;

	// bus decode
	wire        acc      = hsel & htrans[1] & hready;
	wire        wr_cmd   = dp_wr & (dp_addr == SCD_OFF_CMD);
	wire        wr_param = dp_wr & (dp_addr == SCD_OFF_PARAM);
	wire        wr_apply = dp_wr & (dp_addr == SCD_OFF_APPLY);
	wire        wr_stat  = dp_wr & (dp_addr == SCD_OFF_STATUS);
	wire        hdr_ok   = (hwdata[7:0] == SCD_OPCODE) & (hwdata[11:8] == SCD_DEST);
	wire        cmd_ok   = wr_cmd & hdr_ok & (state != SCD_UNPACK);
	wire        cmd_bad  = wr_cmd & ~hdr_ok & (state != SCD_UNPACK);
	wire        byte_in  = wr_param & (state == SCD_COLLECT);
	// commit only on the image size command
	wire        commit   = wr_apply & (state == SCD_STAGED);
	wire        issue    = (state == SCD_UNPACK) & ~issued_all;
	wire        err_clr  = wr_stat & hwdata[SCD_ST_ERR];
	wire [7:0]  rd_addr  = haddr[7:0];
	wire [31:0] st_word  = {22'h0, param_cnt, hdr_err, (state == SCD_STAGED), state};
	wire [31:0] fl_word  = {24'h000000, field_invert, offset_binary, interlaced, ext_de_en,
	                        pixel_format, clk_rising, stereo_en};
	wire [31:0] rd_mux   = (rd_addr == SCD_OFF_CMD)    ? {20'h00000, last_hdr} :
	                       (rd_addr == SCD_OFF_PARAM)  ? {26'h0, param_cnt} :
	                       (rd_addr == SCD_OFF_STATUS) ? st_word :
	                       (rd_addr == SCD_OFF_FLAGS)  ? fl_word :
	                       (rd_addr == SCD_OFF_PCLK)   ? pixclk_khz : 32'h0000_0000;

	// flag bytes use bit 0 only
	wire        s_stereo = stage[SCD_B_STEREO*8];
	wire        s_clkpol = stage[SCD_B_CLKPOL*8];
	wire        s_extde  = stage[SCD_B_EXTDE*8];
	wire        s_ilace  = stage[SCD_B_ILACE*8];
	wire        s_offbin = stage[SCD_B_OFFBIN*8];
	wire        s_finv   = stage[SCD_B_FINV*8];
	wire [7:0]  s_dsamp  = scd_byte(stage, SCD_B_DSAMPLE);
	wire [1:0]  s_pixfmt = stage[SCD_B_PIXFMT*8 +: 2];
	wire [31:0] s_pclk   = scd_word(stage, SCD_B_PCLK);
	// halve clock when down-sampling is on
	wire [31:0] s_pclk_e = (s_dsamp != 8'h00) ? {1'b0, s_pclk[31:1]} : s_pclk;

	scd_param_mem #(
		.DEPTH (SCD_PARAM_LEN),
		.AW    (SCD_IDX_W),
		.DW    (8)
	) u_mem (
		.hclk    (hclk),
		.hresetn (hresetn),
		.we      (byte_in),
		.waddr   (param_cnt),
		.wdata   (hwdata[7:0]),
		.raddr   (rd_idx),
		.rdata   (mem_rdata)
	);

	always_comb begin
		next_state = state;
		case (state)
			SCD_IDLE: begin
				if (cmd_ok)
					next_state = SCD_COLLECT;
			end
			SCD_COLLECT: begin
				if (cmd_bad)
					next_state = SCD_IDLE;
				else if (byte_in && param_cnt == SCD_LAST_IDX)
					next_state = SCD_UNPACK;
			end
			SCD_UNPACK: begin
				if (cap_vld && cap_idx == SCD_LAST_IDX)
					next_state = SCD_STAGED;
			end
			SCD_STAGED: begin
				if (cmd_ok)
					next_state = SCD_COLLECT;
				else if (cmd_bad || commit)
					next_state = SCD_IDLE;
			end
			default: next_state = SCD_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr     <= 1'b0;
			dp_addr   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			dp_wr     <= acc & hwrite;
			dp_addr   <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (acc && !hwrite)
				hrdata <= rd_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= SCD_IDLE;
			last_hdr  <= 12'h000;
			param_cnt <= 6'h00;
			hdr_err   <= 1'b0;
		end else begin
			state <= next_state;
			if (wr_cmd && state != SCD_UNPACK)
				last_hdr <= hwdata[11:0];
			if (cmd_ok)
				param_cnt <= 6'h00;
			else if (byte_in)
				param_cnt <= param_cnt + 6'h01;
			// a new fault wins over a clear in the same cycle
			if (cmd_bad)
				hdr_err <= 1'b1;
			else if (err_clr)
				hdr_err <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_idx     <= 6'h00;
			issued_all <= 1'b0;
			cap_vld    <= 1'b0;
			cap_idx    <= 6'h00;
			stage      <= '0;
		end else begin
			cap_vld <= issue;
			cap_idx <= rd_idx;
			if (state != SCD_UNPACK) begin
				rd_idx     <= 6'h00;
				issued_all <= 1'b0;
			end else if (issue) begin
				rd_idx     <= rd_idx + 6'h01;
				issued_all <= (rd_idx == SCD_LAST_IDX);
			end
			if (cap_vld)
				stage[{cap_idx, 3'b000} +: 8] <= mem_rdata;
		end
	end

	// all outputs load together on commit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stereo_en                     <= 1'b0;
			clk_rising                    <= 1'b0;
			pixel_format                  <= 2'b00;
			ext_de_en                     <= 1'b0;
			interlaced                    <= 1'b0;
			offset_binary                 <= 1'b0;
			field_invert                  <= 1'b0;
			total_ppl                     <= SCD_RST_HALF;
			total_lpf                     <= SCD_RST_HALF;
			act_first_pixel               <= SCD_RST_HALF;
			act_first_line                <= SCD_RST_HALF;
			act_ppl                       <= SCD_RST_HALF;
			act_lpf                       <= SCD_RST_HALF;
			bottom_first_line             <= SCD_RST_HALF;
			pixclk_khz                    <= SCD_RST_WORD;
			color_matrix_conversion_coef0 <= SCD_RST_HALF;
			color_matrix_conversion_coef1 <= SCD_RST_HALF;
			color_matrix_conversion_coef2 <= SCD_RST_HALF;
		end else if (commit) begin
			stereo_en                     <= s_stereo;
			clk_rising                    <= s_clkpol;
			pixel_format                  <= s_pixfmt;
			ext_de_en                     <= s_extde;
			interlaced                    <= s_ilace;
			offset_binary                 <= s_offbin;
			field_invert                  <= s_finv & s_ilace;
			total_ppl                     <= scd_half(stage, SCD_B_TOT_PPL);
			total_lpf                     <= scd_half(stage, SCD_B_TOT_LPF);
			act_first_pixel               <= scd_half(stage, SCD_B_ACT_FP);
			act_first_line                <= scd_half(stage, SCD_B_ACT_FL);
			act_ppl                       <= scd_half(stage, SCD_B_ACT_PPL);
			act_lpf                       <= scd_half(stage, SCD_B_ACT_LPF);
			bottom_first_line             <= scd_half(stage, SCD_B_BOT_FL);
			pixclk_khz                    <= s_pclk_e;
			// s2.10 coefficients passed as raw signed words
			color_matrix_conversion_coef0 <= scd_half(stage, SCD_B_COEF0);
			color_matrix_conversion_coef1 <= scd_half(stage, SCD_B_COEF1);
			color_matrix_conversion_coef2 <= scd_half(stage, SCD_B_COEF2);
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_commit;
		wr_apply && state == SCD_STAGED;
	endsequence

	sequence s_good_hdr;
		wr_cmd && hdr_ok && state == SCD_IDLE;
	endsequence

	a_hdr_accept: assert property (s_good_hdr |=> state == SCD_COLLECT && param_cnt == 6'h00)
		else $error("valid header not accepted");
	a_hdr_reject: assert property (wr_cmd && !hdr_ok && state == SCD_IDLE
		|=> state == SCD_IDLE && hdr_err)
		else $error("foreign header not flagged");
	a_stereo_flag: assert property (s_commit |=> stereo_en == $past(stage[SCD_B_STEREO*8]))
		else $error("stereo flag mismatch");
	a_clock_edge: assert property (s_commit |=> clk_rising == $past(s_clkpol))
		else $error("clock edge mismatch");
	a_pixel_fmt: assert property (s_commit |=> pixel_format == $past(stage[SCD_B_PIXFMT*8 +: 2]))
		else $error("pixel format mismatch");
	a_ext_de: assert property (s_commit |=> ext_de_en == $past(s_extde))
		else $error("data enable flag mismatch");
	a_scan_type: assert property (s_commit |=> interlaced == $past(s_ilace))
		else $error("interlace flag mismatch");
	a_offset_bin: assert property (s_commit |=> offset_binary == $past(s_offbin))
		else $error("coding flag mismatch");
	a_field_inv: assert property (field_invert |-> interlaced)
		else $error("field inversion on progressive source");
	a_total_lsb: assert property (s_commit |=> total_ppl[7:0] == $past(stage[SCD_B_TOT_PPL*8 +: 8])
		&& total_ppl[15:8] == $past(stage[SCD_B_TOT_PPL*8+8 +: 8]))
		else $error("total pixels byte order wrong");
	a_active_win: assert property (s_commit |=> act_lpf == $past(scd_half(stage, SCD_B_ACT_LPF)))
		else $error("active lines mismatch");
	a_pclk_half: assert property ((s_commit and (s_dsamp != 8'h00)) |=> pixclk_khz == ($past(s_pclk) >> 1))
		else $error("down-sampled clock not halved");
	a_coef_load: assert property (s_commit |=> color_matrix_conversion_coef0
		== $past(scd_half(stage, SCD_B_COEF0)))
		else $error("coefficient mismatch");
	a_cfg_hold: assert property (!commit |=> $stable(pixclk_khz) && $stable(act_ppl))
		else $error("configuration changed without commit");
	a_unpack_len: assert property ($rose(state == SCD_UNPACK) |-> ##[36:37] state == SCD_STAGED)
		else $error("unpack did not finish in time");

endmodule
`default_nettype wire

// ===== sim/scd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scd_host_model (
	// bus clock and response
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// bus request
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h5a5a_a5a5;
	end

	// one single word transfer; call just after a rising edge
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? wd : ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		// released data lines must not look like a held value
		hwdata <= ~hwdata;
	endtask
endmodule
`default_nettype wire

// ===== sim/scd_source_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scd_source_config_tb;
	import scd_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, pixclk_khz;
	logic [1:0]  htrans, pixel_format;
	logic [2:0]  hsize;
	logic        stereo_en, clk_rising, ext_de_en, interlaced, offset_binary, field_invert;
	logic [15:0] total_ppl, total_lpf, act_first_pixel, act_first_line, act_ppl, act_lpf;
	logic [15:0] bottom_first_line;
	logic [15:0] color_matrix_conversion_coef0, color_matrix_conversion_coef1;
	logic [15:0] color_matrix_conversion_coef2;
	logic [7:0]  pb [35];
	logic [7:0]  act [35];
	int          errors = 0;
	int          check_count = 0;

	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;

	scd_source_config u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
		.hwdata, .hrdata, .hreadyout, .hresp, .stereo_en, .clk_rising, .pixel_format, .ext_de_en,
		.interlaced, .offset_binary, .field_invert, .total_ppl, .total_lpf, .act_first_pixel,
		.act_first_line, .act_ppl, .act_lpf, .bottom_first_line, .pixclk_khz,
		.color_matrix_conversion_coef0, .color_matrix_conversion_coef1,
		.color_matrix_conversion_coef2);

	scd_host_model u_host (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata);

	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		u_host.xfer(1'b1, {24'h0, a}, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		u_host.xfer(1'b0, {24'h0, a}, 32'h0, d);
	endtask

	task automatic build(input logic [7:0] s, input logic [1:0] fmt, input logic [7:0] ds);
		for (int k = 0; k < 35; k++)
			pb[k] = 8'(k * 7 + s * 3);
		// seeds pick field inversion per source kind
		// flag bytes carry junk above bit 0
		for (int k = 4; k <= 10; k++)
			pb[k] = {7'h55, s[k-4]};
		pb[6] = {6'h2a, fmt};
		pb[3] = ds;
		// bottom line after first line, inside active lines
		pb[22] = 8'hff;
		{pb[24], pb[23]} = {pb[18], pb[17]} + 16'h0001;
		if (fmt == 2'd0) begin
			{pb[30], pb[29], pb[32], pb[31], pb[34], pb[33]} = 48'h0400_0000_0000;
		end
	endtask

	task automatic send(input logic [7:0] op, input logic [3:0] dst, input int n);
		logic [31:0] s;
		int i;
		// sent only while an external source displays
		wr(SCD_OFF_CMD, {20'h0, dst, op});
		for (int k = 0; k < n; k++)
			wr(SCD_OFF_PARAM, {24'h0, pb[k]});
		i = 0;
		if (n == 35 && op == SCD_OPCODE && dst == SCD_DEST) begin
			do begin
				rd(SCD_OFF_STATUS, s);
				i++;
			end while (s[1:0] !== 2'b10 && i < 100);
			chk("staged state", 64'h2, {62'h0, s[1:0]});
		end
	endtask

	task automatic check_out();
		logic [31:0] pk;
		logic [7:0]  f;
		logic [31:0] r;
		@(posedge hclk);
		pk = {act[28], act[27], act[26], act[25]};
		if (act[3] != 8'h00)
			pk = pk >> 1;
		f = {act[10][0] & act[8][0], act[9][0], act[8][0], act[7][0], act[6][1:0], act[5][0],
			act[4][0]};
		chk("flag outputs", {56'h0, f}, {56'h0, field_invert, offset_binary, interlaced, ext_de_en, pixel_format, clk_rising, stereo_en});
		chk("total", {32'h0, act[12], act[11], act[14], act[13]}, {32'h0, total_ppl, total_lpf});
		chk("active", {act[16], act[15], act[18], act[17], act[20], act[19], act[22], act[21]}, {act_first_pixel, act_first_line, act_ppl, act_lpf});
		chk("bottom", {48'h0, act[24], act[23]}, {48'h0, bottom_first_line});
		chk("pixclk", {32'h0, pk}, {32'h0, pixclk_khz});
		chk("coef", {16'h0, act[30], act[29], act[32], act[31], act[34], act[33]}, {16'h0, color_matrix_conversion_coef0, color_matrix_conversion_coef1, color_matrix_conversion_coef2});
		rd(SCD_OFF_FLAGS, r);
		chk("flags reg", {56'h0, f}, {56'h0, r[7:0]});
		rd(SCD_OFF_PCLK, r);
		chk("pclk reg", {32'h0, pk}, {32'h0, r});
	endtask

	task automatic t_reset();
		logic [31:0] s;
		chk("bus idle", 64'h2, {62'h0, hreadyout, hresp});
		rd(SCD_OFF_STATUS, s);
		chk("status", 64'h0, {32'h0, s});
		check_out();
		$display("test reset done");
	endtask

	task automatic t_formats();
		logic [7:0] seeds [4] = '{8'h7f, 8'h40, 8'h55, 8'h2a};
		for (int i = 0; i < 4; i++) begin
			build(seeds[i], 2'(i), 8'h00);
			send(SCD_OPCODE, SCD_DEST, 35);
			check_out();
			wr(SCD_OFF_APPLY, 32'h1);
			act = pb;
			check_out();
		end
		$display("test formats done");
	endtask

	task automatic t_downsample();
		for (int d = 1; d <= 2; d++) begin
			build(8'h33, 2'd2, 8'(d));
			send(SCD_OPCODE, SCD_DEST, 35);
			wr(SCD_OFF_APPLY, 32'h1);
			act = pb;
			check_out();
		end
		$display("test downsample done");
	endtask

	task automatic t_bad_header();
		logic [31:0] s;
		logic [11:0] hdr [2] = '{12'h423, 12'h522};
		for (int i = 0; i < 2; i++) begin
			build(8'h00, 2'd1, 8'h00);
			send(hdr[i][7:0], hdr[i][11:8], 35);
			rd(SCD_OFF_STATUS, s);
			chk("bad header status", 64'h8, {60'h0, s[3:0]});
			rd(SCD_OFF_CMD, s);
			chk("last header", {52'h0, hdr[i]}, {52'h0, s[11:0]});
			wr(SCD_OFF_APPLY, 32'h1);
			check_out();
			wr(SCD_OFF_STATUS, 32'h8);
			rd(SCD_OFF_STATUS, s);
			chk("error cleared", 64'h0, {63'h0, s[3]});
		end
		$display("test bad header done");
	endtask

	task automatic t_partial();
		logic [31:0] s;
		build(8'h2a, 2'd3, 8'h00);
		send(SCD_OPCODE, SCD_DEST, 20);
		rd(SCD_OFF_STATUS, s);
		chk("partial status", {54'h0, 6'd20, 4'h1}, {54'h0, s[9:0]});
		rd(SCD_OFF_PARAM, s);
		chk("param count", 64'h14, {58'h0, s[5:0]});
		wr(SCD_OFF_APPLY, 32'h1);
		check_out();
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, s);
		chk("unmapped read", 64'h0, {32'h0, s});
		// good header restarts a half-sent block
		send(SCD_OPCODE, SCD_DEST, 35);
		wr(SCD_OFF_APPLY, 32'h1);
		act = pb;
		check_out();
		$display("test partial and unmapped done");
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		for (int k = 0; k < 35; k++)
			act[k] = 8'h00;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_formats();
		t_downsample();
		t_bad_header();
		t_partial();
		finish_test();
	end

	initial begin
		#1000000;
		errors++;
		$display("watchdog expired");
		finish_test();
	end
endmodule
`default_nettype wire
